// file: logic/conv_sequencer.v
/*
 Conversion sequencer: periodic timer, conversion busy window and result
 delivery. Assumes start requests and shutdown come from the same clock.
*/
`timescale 1ns/10ps
`include "temp_sensor_consts.vh"

module conv_sequencer #(
  parameter PERIOD_CYC = `CONV_PERIOD_CYC,
  parameter CONV_CYC   = `CONV_TIME_CYC
) (
  input  wire                     sys_clk_i,
  input  wire                     resetn_i,
  input  wire                     clk_en_i,
  input  wire                     shutdown_i,
  input  wire                     restart_i,
  input  wire                     access_end_i,
  input  wire [`TEMP_WIDTH-1:0]   sample_i,
  output reg                      busy_o,
  output reg                      done_o,
  output reg  [`TEMP_WIDTH-1:0]   result_o
);

  reg [31:0] timer_q;
  reg [31:0] conv_q;
  wire       start_w;

  // A conversion in flight is never restarted by serial activity.
  assign start_w = !busy_o && (restart_i ||
                   (!shutdown_i && (access_end_i || timer_q >= PERIOD_CYC - 1)));

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer_q  <= 32'h00000000;
      conv_q   <= 32'h00000000;
      busy_o   <= 1'b0;
      done_o   <= 1'b0;
      result_o <= `TEMP_RESET;
    end else if (clk_en_i) begin
      done_o <= 1'b0;
      if (shutdown_i && !restart_i) begin
        timer_q <= 32'h00000000;
      end else if (access_end_i || restart_i || timer_q >= PERIOD_CYC - 1) begin
        timer_q <= 32'h00000000;
      end else begin
        timer_q <= timer_q + 32'h00000001;
      end
      if (start_w) begin
        busy_o <= 1'b1;
        conv_q <= 32'h00000000;
      end else if (busy_o) begin
        if (conv_q >= CONV_CYC - 1) begin
          busy_o   <= 1'b0;
          done_o   <= 1'b1;
          result_o <= sample_i;
        end else begin
          conv_q <= conv_q + 32'h00000001;
        end
      end
    end
  end

endmodule

// file: logic/temp_sensor_consts.vh
/*
 Constants for the temperature sensor serial readout: field positions,
 frame lengths, reset values and conversion timing. Assumes the includer
 works from a 40 MHz system clock.
*/
`ifndef TEMP_SENSOR_CONSTS_VH
`define TEMP_SENSOR_CONSTS_VH

`define CLK_FREQ_HZ        40000000
`define CONV_PERIOD_MS     1500
`define CONV_TIME_US       1200
`define CONV_PERIOD_CYC    (`CLK_FREQ_HZ / 1000 * `CONV_PERIOD_MS)
`define CONV_TIME_CYC      (`CLK_FREQ_HZ / 1000000 * `CONV_TIME_US)
`define TEMP_WIDTH         14
`define SIGN_BIT_POSITION  13
`define FRAME_BITS         16
`define LEAD_ZERO_BITS     2
`define CTRL_WIDTH         16
`define CTRL_PD_BIT        13
`define CTRL_RESET         16'h0000
`define TEMP_RESET         14'h0000

`endif

// file: logic/temp_sensor_readout.v
/*
 Digital side of a micropower temperature sensor: conversion scheduling,
 result buffering, and the slave serial port. Assumes the serial pins are
 asynchronous to sys_clk_i and that the serial clock is far slower.
*/
`timescale 1ns/10ps
`include "temp_sensor_consts.vh"

module temp_sensor_readout #(
  parameter PERIOD_CYC = `CONV_PERIOD_CYC,
  parameter CONV_CYC   = `CONV_TIME_CYC
) (
  input  wire                     sys_clk_i,
  input  wire                     resetn_i,
  input  wire                     clk_en_i,
  input  wire                     sclk_i,
  input  wire                     cs_n_i,
  input  wire                     sdi_i,
  input  wire [`TEMP_WIDTH-1:0]   adc_sample_i,
  output reg                      sdo_o,
  output reg                      sdo_oe_o,
  output reg                      analog_on_o,
  output reg                      shutdown_o,
  output reg  [`TEMP_WIDTH-1:0]   temperature_value_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Only the second stage is read by logic.

  localparam       PIN_COUNT = 3;
  localparam       PIN_SCLK  = 0;
  localparam       PIN_CS    = 1;
  localparam       PIN_SDI   = 2;
  // Rest levels of the pins: clock and select idle high, data in low.
  localparam [2:0] PIN_IDLE  = 3'h3;

  wire [PIN_COUNT-1:0] pin_raw_w;
  wire [PIN_COUNT-1:0] pin_sync_w;

  assign pin_raw_w = {sdi_i, cs_n_i, sclk_i};

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g = g + 1) begin : g_pin_sync
      reg [1:0] stage_q;

      // Reset to the rest level, so that no false edge follows reset.
      always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          stage_q <= {2{PIN_IDLE[g]}};
        end else if (clk_en_i) begin
          stage_q <= {stage_q[0], pin_raw_w[g]};
        end
      end

      assign pin_sync_w[g] = stage_q[1];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection on the synchronised serial clock and chip select.

  reg sclk_d1_q;
  reg cs_d1_q;

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_d1_q <= 1'b1;
      cs_d1_q   <= 1'b1;
    end else if (clk_en_i) begin
      sclk_d1_q <= pin_sync_w[PIN_SCLK];
      cs_d1_q   <= pin_sync_w[PIN_CS];
    end
  end

  wire sclk_w = pin_sync_w[PIN_SCLK];
  wire cs_w   = pin_sync_w[PIN_CS];
  wire sdi_w  = pin_sync_w[PIN_SDI];
  wire sel_w  = !cs_w;
  wire rise_w = sel_w && sclk_w && !sclk_d1_q;
  wire fall_w = sel_w && !sclk_w && sclk_d1_q;
  // An access ends when select is released, however many bits were shifted.
  wire end_w  = cs_w && !cs_d1_q;

  //////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer and buffer.

  wire                   busy_w;
  wire                   done_w;
  wire [`TEMP_WIDTH-1:0] result_w;
  reg                    restart_q;

  conv_sequencer #(
    .PERIOD_CYC (PERIOD_CYC),
    .CONV_CYC   (CONV_CYC)
  ) u_seq (
    .sys_clk_i    (sys_clk_i),
    .resetn_i     (resetn_i),
    .clk_en_i     (clk_en_i),
    .shutdown_i   (shutdown_o),
    .restart_i    (restart_q),
    .access_end_i (end_w),
    .sample_i     (adc_sample_i),
    .busy_o       (busy_w),
    .done_o       (done_w),
    .result_o     (result_w)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Serial frame registers.

  reg [3:0]             rx_cnt_q;
  reg [3:0]             tx_cnt_q;
  reg [`CTRL_WIDTH-1:0] rx_shift_q;
  reg [`CTRL_WIDTH-1:0] control_word_q;
  reg [`FRAME_BITS-1:0] tx_frame_q;

  //////////////////////////////////////////////////////////////////////////////
  // Port state, one-hot: deselected, selected before the first falling edge,
  // and shifting. The value register is refreshed only on the first falling edge, leaving the idle or armed state.

  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_ARMED = 3'h2;
  localparam [2:0] ST_SHIFT = 3'h4;

  reg  [2:0] port_state_q;
  reg  [2:0] port_state_d;
  wire       first_w;

  always @* begin
    port_state_d = port_state_q;
    case (port_state_q)
      ST_IDLE: begin
        if (sel_w && fall_w) begin
          port_state_d = ST_SHIFT;
        end else if (sel_w) begin
          port_state_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (!sel_w) begin
          port_state_d = ST_IDLE;
        end else if (fall_w) begin
          port_state_d = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!sel_w) begin
          port_state_d = ST_IDLE;
        end
      end
      default: begin
        port_state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_state_q <= ST_IDLE;
    end else if (clk_en_i) begin
      port_state_q <= port_state_d;
    end
  end

  // Any state but shifting counts as before the first falling edge of the access.
  assign first_w = (port_state_q != ST_SHIFT);

  //////////////////////////////////////////////////////////////////////////////
  // Result buffer and value register.

  // Buffer holds every finished result; a result that lands mid-read waits
  // here for the next access rather than corrupting the frame in flight.
  reg  [`TEMP_WIDTH-1:0] buffer_q;
  wire [`TEMP_WIDTH-1:0] fresh_w;
  wire                   load_w;

  // A result finishing on the very edge of the first fall is taken at once.
  assign fresh_w = done_w ? result_w : buffer_q;
  assign load_w  = fall_w && first_w && (tx_cnt_q == 4'h0);

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      buffer_q            <= `TEMP_RESET;
      temperature_value_o <= `TEMP_RESET;
    end else if (clk_en_i) begin
      if (done_w) begin
        buffer_q <= result_w;
      end
      if (load_w) begin
        temperature_value_o <= fresh_w;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit side: two leading zeros, then the value most significant bit first.

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_cnt_q   <= 4'h0;
      tx_frame_q <= 16'h0000;
      sdo_o      <= 1'b0;
      sdo_oe_o   <= 1'b0;
    end else if (clk_en_i) begin
      if (!sel_w) begin
        tx_cnt_q <= 4'h0;
        sdo_oe_o <= 1'b0;
        sdo_o    <= 1'b0;
      end else begin
        sdo_oe_o <= 1'b1;
        if (fall_w) begin
          if (tx_cnt_q == 4'h0) begin
            // Frame reload; the first one of an access also refreshes the value.
            if (first_w) begin
              tx_frame_q <= {{`LEAD_ZERO_BITS{1'b0}}, fresh_w};
            end else begin
              tx_frame_q <= {{`LEAD_ZERO_BITS{1'b0}}, temperature_value_o};
            end
            sdo_o <= 1'b0;
          end else begin
            sdo_o <= tx_frame_q[`FRAME_BITS-1-tx_cnt_q];
          end
          tx_cnt_q <= tx_cnt_q + 4'h1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive side and control register.

  wire [`CTRL_WIDTH-1:0] rx_word_w;
  wire                   last_rise_w;

  // The word as it will stand once the current rising edge is taken.
  assign rx_word_w   = {rx_shift_q[`CTRL_WIDTH-2:0], sdi_w};
  assign last_rise_w = rise_w && (rx_cnt_q == 4'hF);

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_cnt_q   <= 4'h0;
      rx_shift_q <= `CTRL_RESET;
    end else if (clk_en_i) begin
      if (!sel_w) begin
        rx_cnt_q <= 4'h0;
      end else if (rise_w) begin
        rx_shift_q <= rx_word_w;
        rx_cnt_q   <= rx_cnt_q + 4'h1;
      end
    end
  end

  // A partial word never reaches the control register, since only every
  // sixteenth rising edge of an unbroken select window loads it.
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      control_word_q <= `CTRL_RESET;
      shutdown_o     <= 1'b0;
      restart_q      <= 1'b0;
    end else if (clk_en_i) begin
      restart_q <= 1'b0;
      if (last_rise_w) begin
        control_word_q <= rx_word_w;
        // The third bit received sits at the power-down position after 16 shifts.
        shutdown_o     <= rx_word_w[`CTRL_PD_BIT];
        if (control_word_q[`CTRL_PD_BIT] && !rx_word_w[`CTRL_PD_BIT]) begin
          restart_q <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Analog power indication follows the conversion window one clock later.

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      analog_on_o <= 1'b0;
    end else if (clk_en_i) begin
      analog_on_o <= busy_w;
    end
  end

endmodule

// file: tb/serial_master.sv
/* Serial master model: makes the serial clock and frames each transfer.
 Assumes a 25 ns system clock; inputs change on its falling edge. */
`timescale 1ns/10ps
module serial_master (
  input  wire  sys_clk_i,
  input  wire  sdo_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o
);
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end
  // Data out is taken late in the high phase, since it settles up to three clocks after a fall.
  task automatic xfer(input logic [31:0] wr, input int n, input bit sel, output logic [31:0] rd);
    rd = '0;
    cs_n_o = !sel;
    repeat (4) @(negedge sys_clk_i);
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b0;
      sdi_o  = wr[31-i];
      repeat (4) @(negedge sys_clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      rd[31-i] = sdo_i;
    end
    repeat (4) @(negedge sys_clk_i);
    cs_n_o = 1'b1;
    sdi_o  = !sdi_o;
    repeat (8) @(negedge sys_clk_i);
  endtask
endmodule

// file: tb/temp_sensor_readout_checker.sv
/* Port checker for the temperature sensor readout.
 Assumes the serial clock half period spans at least four system clocks. */
`timescale 1ns/10ps
`include "temp_sensor_consts.vh"
module readout_checker #(
  parameter PERIOD_CYC = 200,
  parameter CONV_CYC   = 40
) (
  input wire                   sys_clk_i,
  input wire                   resetn_i,
  input wire                   sclk_i,
  input wire                   cs_n_i,
  input wire                   sdo_o,
  input wire                   sdo_oe_o,
  input wire                   analog_on_o,
  input wire                   shutdown_o,
  input wire [`TEMP_WIDTH-1:0] temperature_value_o
);
  // Pins pass a two-stage synchroniser, so causes are looked up three clocks back.
  localparam int PW = PERIOD_CYC + 8;
  localparam int CL = CONV_CYC - 3;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  a_oe_release: assert property ($rose(cs_n_i) |-> ##[1:5] !sdo_oe_o)
    else $error("data out still driven");
  a_sdo_on_fall: assert property (sdo_oe_o && $changed(sdo_o) |-> !$past(sclk_i, 3))
    else $error("data out moved off a falling edge");
  a_value_in_frame: assert property ($changed(temperature_value_o) |-> !$past(cs_n_i, 3))
    else $error("value moved outside a frame");
  a_no_conv_shutdown: assert property ($rose(analog_on_o) |-> !$past(shutdown_o))
    else $error("conversion started in shutdown");
  a_conv_length: assert property ($rose(analog_on_o) |-> ##CL analog_on_o ##[1:4] !analog_on_o)
    else $error("conversion length wrong");
  a_periodic_start: assert property ($fell(analog_on_o) |-> ##[1:PW] (analog_on_o || shutdown_o))
    else $error("periodic conversion missing");
  a_access_start: assert property ($rose(cs_n_i) && !analog_on_o && !shutdown_o |-> ##[1:8] analog_on_o)
    else $error("no conversion after access");
  a_ctrl_in_frame: assert property ($changed(shutdown_o) |-> !$past(cs_n_i, 3))
    else $error("power state moved outside a frame");
  c_shutdown: cover property ($rose(shutdown_o));
  c_load: cover property ($changed(temperature_value_o));
  c_conv: cover property ($rose(analog_on_o));
endmodule
bind temp_sensor_readout readout_checker #(.PERIOD_CYC(PERIOD_CYC), .CONV_CYC(CONV_CYC)) i_readout_checker (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .analog_on_o(analog_on_o), .shutdown_o(shutdown_o),
  .temperature_value_o(temperature_value_o));

// file: tb/temp_sensor_readout_tb.sv
/* Bench for the temperature sensor readout, driven through the master model.
 Assumes shortened timer counts of 200 and 40 system clocks. */
`timescale 1ns/10ps
`include "temp_sensor_consts.vh"
module temp_sensor_readout_tb;
  localparam logic [13:0] C_NEG = 14'(16384 - 40 * 32);
  localparam logic [13:0] C_POS = 14'(25 * 32);
  localparam logic [13:0] C_HOT = 14'(100 * 32);
  localparam logic [31:0] PD_WR = 32'h0001 << (`CTRL_PD_BIT + 16);
  logic sys_clk = 1'b0;
  logic rstn, sclk, cs_n, sdi, sdo, sdo_oe, aon, sd;
  logic [13:0] adc, tval;
  logic [31:0] rd;
  int mismatches = 0;
  int checks_done = 0;
  wire sdo_w = sdo_oe ? sdo : !sdo;
  initial forever #12.5 sys_clk = ~sys_clk;
  temp_sensor_readout #(.PERIOD_CYC(200), .CONV_CYC(40)) i_temp_sensor_readout (
    .sys_clk_i(sys_clk), .resetn_i(rstn), .clk_en_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n),
    .sdi_i(sdi), .adc_sample_i(adc), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .analog_on_o(aon),
    .shutdown_o(sd), .temperature_value_o(tval));
  serial_master i_serial_master (.sys_clk_i(sys_clk), .sdo_i(sdo_w), .sclk_o(sclk),
    .cs_n_o(cs_n), .sdi_o(sdi));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_aon(input logic v);
    for (int k = 0; k < 400 && aon !== v; k++) @(negedge sys_clk);
    chk("analog wait", v, aon);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    finish_test;
  end
  initial begin
    rstn = 1'b0;
    adc = C_NEG;
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    chk("shutdown", 0, sd);
    wait_aon(1'b1);
    wait_aon(1'b0);
    i_serial_master.xfer(32'h0, 32, 1'b1, rd);
    chk("frame", {2'b00, C_NEG, 2'b00, C_NEG}, rd);
    chk("release", 0, sdo_oe);
    chk("value", C_NEG, tval);
    adc = C_POS;
    // This frame opens while the access-end conversion still runs.
    i_serial_master.xfer(32'h0, 16, 1'b1, rd);
    chk("frame", {2'b00, C_NEG}, rd[31:16]);
    chk("value", C_NEG, tval);
    i_serial_master.xfer(PD_WR, 16, 1'b0, rd);
    chk("shutdown", 0, sd);
    i_serial_master.xfer(PD_WR, 16, 1'b1, rd);
    chk("frame", {2'b00, C_POS}, rd[31:16]);
    chk("shutdown", 1, sd);
    adc = C_HOT;
    repeat (300) @(negedge sys_clk);
    chk("analog", 0, aon);
    i_serial_master.xfer(PD_WR, 16, 1'b1, rd);
    chk("frame", {2'b00, C_POS}, rd[31:16]);
    i_serial_master.xfer(32'h0, 10, 1'b1, rd);
    chk("shutdown", 1, sd);
    i_serial_master.xfer(32'h0, 16, 1'b1, rd);
    chk("shutdown", 0, sd);
    wait_aon(1'b1);
    chk("analog", 1, aon);
    wait_aon(1'b0);
    i_serial_master.xfer(32'h0, 16, 1'b1, rd);
    chk("frame", {2'b00, C_HOT}, rd[31:16]);
    finish_test;
  end
endmodule
